// file: skip_sub_pkg.sv
`default_nettype none
package skip_sub_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_FLAGS = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_MEM_BASE = 12'h040;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;

  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 4;
  localparam int CMD_ADDR_LSB = 8;

  // Operation codes
  localparam logic [2:0] OP_INC_TO_ACC_SKIP_ZERO = 3'h0;
  localparam logic [2:0] OP_SKIP_IF_NONZERO = 3'h1;
  localparam logic [2:0] OP_SKIP_IF_NONZERO_BIT = 3'h2;
  localparam logic [2:0] OP_SUBTRACT_TO_ACC = 3'h3;
  localparam logic [2:0] OP_SUBTRACT_TO_MEM = 3'h4;
  localparam logic [2:0] OP_NIBBLE_SWAP_IN_PLACE = 3'h5;

  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;
  localparam int FLAG_W = 6;

  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int STAT_CYC_LSB = 8;

  // Values after reset
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;

  // Instruction cycles of one extended instruction
  localparam logic [1:0] CYC_PLAIN = 2'h2;
  localparam logic [1:0] CYC_SKIP = 2'h3;

  typedef enum logic [1:0] {
    S_IDLE,
    S_OPERAND,
    S_EXECUTE,
    S_DUMMY
  } exec_state_t;
endpackage
`default_nettype wire

// file: operand_mem.sv
`timescale 1ns/1ps
`default_nettype none
module operand_mem (
  input wire logic pclk,
  input wire logic [3:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] mem [skip_sub_pkg::MEM_DEPTH];

  // Write port and registered read port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // operand_mem
`default_nettype wire

// file: skip_sub_alu.sv
`timescale 1ns/1ps
`default_nettype none
module skip_sub_alu (
  input wire logic [2:0] op,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] acc,
  input wire logic [7:0] opnd,
  output logic [7:0] result,
  output logic to_acc,
  output logic to_mem,
  output logic set_flags,
  output logic skip,
  output logic [5:0] flags
);
  logic [8:0] diff9;
  logic [4:0] lo5;
  logic [7:0] inc;
  logic [7:0] diff;
  logic ovf;

  // ---------------------------------------------------------------
  // Subtract acc minus operand, incrementer
  // ---------------------------------------------------------------
  always_comb begin
    diff9 = {1'b0, acc} + {1'b0, ~opnd} + 9'h001;
    lo5 = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]} + 5'h01;
    diff = diff9[7:0];
    inc = opnd + 8'h01;
    ovf = (acc[7] ^ opnd[7]) & (acc[7] ^ diff[7]);
    flags = '0;
    flags[skip_sub_pkg::FLAG_C] = diff9[8]; // No borrow sets carry
    flags[skip_sub_pkg::FLAG_AC] = lo5[4];
    flags[skip_sub_pkg::FLAG_Z] = (diff == 8'h00);
    flags[skip_sub_pkg::FLAG_OV] = ovf;
    flags[skip_sub_pkg::FLAG_SC] = ovf ^ diff[7];
    flags[skip_sub_pkg::FLAG_CZ] = (diff == 8'h00);
  end

  // Operation select
  always_comb begin
    result = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    set_flags = 1'b0;
    skip = 1'b0;
    unique case (op)
      skip_sub_pkg::OP_INC_TO_ACC_SKIP_ZERO: begin
        result = inc;
        to_acc = 1'b1;
        skip = (inc == 8'h00);
      end
      skip_sub_pkg::OP_SKIP_IF_NONZERO: begin
        skip = |opnd;
      end
      skip_sub_pkg::OP_SKIP_IF_NONZERO_BIT: begin
        skip = opnd[bit_sel];
      end
      skip_sub_pkg::OP_SUBTRACT_TO_ACC: begin
        result = diff;
        to_acc = 1'b1;
        set_flags = 1'b1;
      end
      skip_sub_pkg::OP_SUBTRACT_TO_MEM: begin
        result = diff;
        to_mem = 1'b1;
        set_flags = 1'b1;
      end
      skip_sub_pkg::OP_NIBBLE_SWAP_IN_PLACE: begin
        result = {opnd[3:0], opnd[7:4]};
        to_mem = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end
endmodule // skip_sub_alu
`default_nettype wire

// file: skip_subtract_swap_exec.sv
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Increment byte into accumulator, memory untouched
// - Skip next when incremented value is zero
// - Taken skip adds dummy cycle, three total
// - Bit test skips when selected bit set
// - Byte test skips when byte nonzero
// - Accumulator minus byte into accumulator
// - Accumulator minus byte back into memory
// - Carry clear on negative, set otherwise
// - Subtractions update all six status flags
// - Swap nibbles of byte in place
module skip_subtract_swap_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic skip_next,
  output logic dummy_cycle
);
  typedef struct packed {
    skip_sub_pkg::exec_state_t state;
    logic [2:0] op;
    logic [2:0] bit_sel;
    logic [3:0] addr;
    logic [7:0] acc;
    logic [5:0] flags;
    logic skip_next;
    logic dummy_cycle;
    logic last_skip;
    logic [1:0] cycles;
    logic pready;
    logic pslverr;
    logic mem_pend;
    logic [31:0] prdata;
  } regs_t;

  regs_t st;
  regs_t next_st;
  logic [3:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] alu_result;
  logic alu_to_acc;
  logic alu_to_mem;
  logic alu_set_flags;
  logic alu_skip;
  logic [5:0] alu_flags;
  logic busy;
  logic access;
  logic commit;
  logic mem_hit;
  logic reg_hit;
  logic bad_op;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  operand_mem u_mem (
    .pclk(pclk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  skip_sub_alu u_alu (
    .op(st.op),
    .bit_sel(st.bit_sel),
    .acc(st.acc),
    .opnd(mem_rdata),
    .result(alu_result),
    .to_acc(alu_to_acc),
    .to_mem(alu_to_mem),
    .set_flags(alu_set_flags),
    .skip(alu_skip),
    .flags(alu_flags)
  );

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input regs_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      skip_sub_pkg::OFS_CMD:
        w = (32'(s.op) << skip_sub_pkg::CMD_OP_LSB)
          | (32'(s.bit_sel) << skip_sub_pkg::CMD_BIT_LSB)
          | (32'(s.addr) << skip_sub_pkg::CMD_ADDR_LSB);
      skip_sub_pkg::OFS_ACC: w = 32'(s.acc);
      skip_sub_pkg::OFS_FLAGS: w = 32'(s.flags);
      skip_sub_pkg::OFS_STATUS:
        w = (32'(s.state != skip_sub_pkg::S_IDLE)
             << skip_sub_pkg::STAT_BUSY)
          | (32'(s.last_skip) << skip_sub_pkg::STAT_SKIP)
          | (32'(s.cycles) << skip_sub_pkg::STAT_CYC_LSB);
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Address decode
  always_comb begin
    busy = (st.state != skip_sub_pkg::S_IDLE);
    access = psel & penable;
    commit = access & st.pready & ~st.pslverr & pwrite;
    mem_hit = (paddr[11:6] == skip_sub_pkg::OFS_MEM_BASE[11:6]);
    reg_hit = (paddr == skip_sub_pkg::OFS_CMD)
            | (paddr == skip_sub_pkg::OFS_ACC)
            | (paddr == skip_sub_pkg::OFS_FLAGS)
            | (paddr == skip_sub_pkg::OFS_STATUS);
    bad_op = (pwdata[skip_sub_pkg::CMD_OP_LSB +: 3]
              > skip_sub_pkg::OP_NIBBLE_SWAP_IN_PLACE);
  end

  // ---------------------------------------------------------------
  // Next state: bus slave and execution sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.skip_next = 1'b0;
    next_st.dummy_cycle = 1'b0;
    mem_addr = st.addr;
    mem_we = 1'b0;
    mem_wdata = alu_result;

    // Access phase: answer, stall or start a memory read
    if (st.pready) begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end else if (access) begin
      if (st.mem_pend) begin
        next_st.prdata = 32'(mem_rdata);
        next_st.pready = 1'b1;
        next_st.mem_pend = 1'b0;
      end else if (busy && paddr != skip_sub_pkg::OFS_STATUS) begin
        next_st.pready = 1'b0;
      end else if (mem_hit && !pwrite) begin
        mem_addr = paddr[5:2];
        next_st.mem_pend = 1'b1;
      end else begin
        next_st.pready = 1'b1;
        next_st.prdata = read_word(paddr, st);
        next_st.pslverr = (!mem_hit && !reg_hit)
          || (pwrite && paddr == skip_sub_pkg::OFS_STATUS)
          || (pwrite && paddr == skip_sub_pkg::OFS_CMD && bad_op);
      end
    end

    // Writes take effect at the edge that completes the transfer
    if (commit) begin
      if (mem_hit) begin
        mem_addr = paddr[5:2];
        mem_we = 1'b1;
        mem_wdata = pwdata[7:0];
      end else if (paddr == skip_sub_pkg::OFS_ACC) begin
        next_st.acc = pwdata[7:0];
      end else if (paddr == skip_sub_pkg::OFS_FLAGS) begin
        next_st.flags = pwdata[skip_sub_pkg::FLAG_W-1:0];
      end else if (paddr == skip_sub_pkg::OFS_CMD) begin
        next_st.op = pwdata[skip_sub_pkg::CMD_OP_LSB +: 3];
        next_st.bit_sel = pwdata[skip_sub_pkg::CMD_BIT_LSB +: 3];
        next_st.addr = pwdata[skip_sub_pkg::CMD_ADDR_LSB +: 4];
        next_st.last_skip = 1'b0;
        next_st.state = skip_sub_pkg::S_OPERAND;
      end
    end

    // Instruction sequence
    unique case (st.state)
      skip_sub_pkg::S_IDLE: begin
        next_st.dummy_cycle = 1'b0;
      end
      skip_sub_pkg::S_OPERAND: begin
        next_st.state = skip_sub_pkg::S_EXECUTE;
      end
      skip_sub_pkg::S_EXECUTE: begin
        if (alu_to_acc) begin
          next_st.acc = alu_result;
        end
        mem_we = alu_to_mem;
        if (alu_set_flags) begin // Skips and swap keep flags
          next_st.flags = alu_flags;
        end
        next_st.skip_next = alu_skip;
        next_st.last_skip = alu_skip;
        if (alu_skip) begin
          next_st.state = skip_sub_pkg::S_DUMMY;
          next_st.dummy_cycle = 1'b1;
          next_st.cycles = skip_sub_pkg::CYC_SKIP;
        end else begin
          next_st.state = skip_sub_pkg::S_IDLE;
          next_st.cycles = skip_sub_pkg::CYC_PLAIN;
        end
      end
      skip_sub_pkg::S_DUMMY: begin
        next_st.state = skip_sub_pkg::S_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.acc <= skip_sub_pkg::ACC_RESET;
      st.flags <= skip_sub_pkg::FLAGS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign skip_next = st.skip_next;
  assign dummy_cycle = st.dummy_cycle;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence exec_of(logic [2:0] o);
    st.state == skip_sub_pkg::S_EXECUTE && st.op == o;
  endsequence

  sequence skip_taken;
    st.state == skip_sub_pkg::S_EXECUTE && alu_skip;
  endsequence

  sequence dummy_then_idle;
    st.dummy_cycle && st.state == skip_sub_pkg::S_DUMMY
      ##1 !st.dummy_cycle && st.state == skip_sub_pkg::S_IDLE
          && st.cycles == skip_sub_pkg::CYC_SKIP;
  endsequence

  a_inc_acc_sum: assert property (
    exec_of(skip_sub_pkg::OP_INC_TO_ACC_SKIP_ZERO) |-> !mem_we
      ##1 st.acc == $past(mem_rdata) + 8'h01)
    else $error("increment result not in accumulator");

  a_inc_skip_zero: assert property (
    exec_of(skip_sub_pkg::OP_INC_TO_ACC_SKIP_ZERO)
      |=> st.skip_next == ($past(mem_rdata) == 8'hff))
    else $error("increment skip decision wrong");

  a_skip_dummy_cycle: assert property (
    skip_taken |=> dummy_then_idle)
    else $error("taken skip lacks one dummy cycle");

  a_bit_skip: assert property (
    exec_of(skip_sub_pkg::OP_SKIP_IF_NONZERO_BIT)
      |-> ##1 st.skip_next == $past(mem_rdata[st.bit_sel]))
    else $error("bit test skip wrong");

  a_byte_skip: assert property (
    exec_of(skip_sub_pkg::OP_SKIP_IF_NONZERO)
      |=> st.skip_next == ($past(mem_rdata) != 8'h00))
    else $error("byte test skip wrong");

  a_sub_acc_diff: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_ACC)
      |=> st.acc == $past(st.acc) - $past(mem_rdata))
    else $error("subtract to accumulator wrong");

  a_sub_mem_diff: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_MEM)
      |-> mem_we && mem_addr == st.addr
          && mem_wdata == st.acc - mem_rdata)
    else $error("subtract to memory wrong");

  a_sub_carry: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_ACC)
      or exec_of(skip_sub_pkg::OP_SUBTRACT_TO_MEM)
      |=> st.flags[skip_sub_pkg::FLAG_C]
          == ($past(st.acc) >= $past(mem_rdata)))
    else $error("carry after subtract wrong");

  a_sub_zero: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_MEM)
      |=> st.flags[skip_sub_pkg::FLAG_Z]
          == ($past(st.acc) == $past(mem_rdata)))
    else $error("zero after subtract wrong");

  a_swap_nibbles: assert property (
    exec_of(skip_sub_pkg::OP_NIBBLE_SWAP_IN_PLACE)
      |-> mem_we && mem_wdata == {mem_rdata[3:0], mem_rdata[7:4]})
    else $error("nibble swap wrong");

  a_flags_kept: assert property (
    st.state == skip_sub_pkg::S_EXECUTE && !alu_set_flags
      |=> $stable(st.flags))
    else $error("flags changed by skip or swap");

  a_no_skip_short: assert property (
    st.state == skip_sub_pkg::S_EXECUTE && !alu_skip
      |=> st.state == skip_sub_pkg::S_IDLE && !st.dummy_cycle
          && st.cycles == skip_sub_pkg::CYC_PLAIN)
    else $error("untaken skip took a dummy cycle");

  // Further subtract flag checks, judged from operands and result, then accumulator, write and dummy cycle checks
  a_sub_aux_carry: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_ACC)
      or exec_of(skip_sub_pkg::OP_SUBTRACT_TO_MEM)
      |=> st.flags[skip_sub_pkg::FLAG_AC]
          == ($past(st.acc[3:0]) >= $past(mem_rdata[3:0])))
    else $error("aux carry after subtract wrong");

  a_sub_acc_zero: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_ACC)
      |=> st.flags[skip_sub_pkg::FLAG_Z] == (st.acc == 8'h00))
    else $error("zero after subtract to accumulator wrong");

  a_sub_acc_ovf: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_ACC)
      |=> st.flags[skip_sub_pkg::FLAG_OV]
          == (($past(st.acc[7]) != $past(mem_rdata[7]))
              && (st.acc[7] != $past(st.acc[7]))))
    else $error("overflow after subtract wrong");

  a_sub_mem_acc_kept: assert property (
    exec_of(skip_sub_pkg::OP_SUBTRACT_TO_MEM) |=> $stable(st.acc))
    else $error("subtract to memory changed accumulator");

  a_test_no_write: assert property (
    exec_of(skip_sub_pkg::OP_SKIP_IF_NONZERO)
      or exec_of(skip_sub_pkg::OP_SKIP_IF_NONZERO_BIT) |-> !mem_we)
    else $error("skip test wrote memory");

  a_dummy_with_skip: assert property (
    st.dummy_cycle |-> st.skip_next)
    else $error("dummy cycle without skip");
endmodule // skip_subtract_swap_exec
`default_nettype wire

// file: seq_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Sequencer side: APB master that issues instructions
// ------------------------------------------------------------
module seq_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // Released lines show no stale value
    pwdata <= ~d;
  endtask
endmodule // seq_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic skip_next;
  logic dummy_cycle;
  int n_fail = 0;
  int num_checks = 0;
  int n_dummy = 0;
  int n_skip = 0;
  int cyc = 0;

  skip_subtract_swap_exec skip_subtract_swap_exec_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .skip_next(skip_next), .dummy_cycle(dummy_cycle));

  seq_model seq_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock, reset, pulse counters and hang limit
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  end
  always @(posedge pclk) begin
    cyc++;
    if (dummy_cycle === 1'b1) n_dummy++;
    if (skip_next === 1'b1) n_skip++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [11:0] ma(input logic [3:0] i);
    return skip_sub_pkg::OFS_MEM_BASE + {6'h00, i, 2'b00};
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic e);
    logic [31:0] r;
    logic er;
    seq_model_i.xfer(1'b1, a, d, r, er);
    check({31'h0, er}, {31'h0, e});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic er;
    seq_model_i.xfer(1'b0, a, 32'h0, r, er);
    check(r, exp);
  endtask

  // Issue one instruction, wait for idle, judge skip and cycles
  task automatic run(input logic [2:0] op, input logic [2:0] b,
      input logic [3:0] m, input logic sk);
    logic [31:0] st;
    logic er;
    int d0;
    int s0;
    int k;
    d0 = n_dummy;
    s0 = n_skip;
    wr(skip_sub_pkg::OFS_CMD, {20'h0, m, 1'b0, b, 1'b0, op}, 1'b0);
    k = 0;
    do begin
      seq_model_i.xfer(1'b0, skip_sub_pkg::OFS_STATUS, 32'h0, st, er);
      k++;
    end while (st[0] !== 1'b0 && k < 20);
    check({31'h0, st[0]}, 32'h0);
    check({30'h0, st[9:8]}, sk ? 32'h3 : 32'h2);
    check(32'(n_dummy - d0), {31'h0, sk});
    check(32'(n_skip - s0), {31'h0, sk});
    check({31'h0, st[1]}, {31'h0, sk});
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_inc();
    wr(ma(4'h2), 32'hff, 1'b0);
    wr(skip_sub_pkg::OFS_FLAGS, 32'h2a, 1'b0);
    run(3'h0, 3'h0, 4'h2, 1'b1);
    rd(skip_sub_pkg::OFS_ACC, 32'h00);
    rd(ma(4'h2), 32'hff);
    wr(ma(4'h5), 32'h7f, 1'b0);
    run(3'h0, 3'h0, 4'h5, 1'b0);
    rd(skip_sub_pkg::OFS_ACC, 32'h80);
    rd(skip_sub_pkg::OFS_FLAGS, 32'h2a);
  endtask

  task automatic t_nz();
    wr(ma(4'h3), 32'h00, 1'b0);
    run(3'h1, 3'h0, 4'h3, 1'b0);
    wr(ma(4'h3), 32'h01, 1'b0);
    run(3'h1, 3'h0, 4'h3, 1'b1);
    wr(ma(4'h4), 32'h80, 1'b0);
    run(3'h2, 3'h7, 4'h4, 1'b1);
    run(3'h2, 3'h6, 4'h4, 1'b0);
    wr(ma(4'h4), 32'h7f, 1'b0);
    run(3'h2, 3'h7, 4'h4, 1'b0);
    run(3'h2, 3'h0, 4'h4, 1'b1);
    rd(skip_sub_pkg::OFS_FLAGS, 32'h2a);
  endtask

  // Both subtract forms over sign, borrow and zero corners
  task automatic t_sub();
    logic [15:0] tbl [5];
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] r;
    logic [5:0] f;
    tbl = '{16'h1020, 16'h2020, 16'h8001, 16'h7fff, 16'h0503};
    for (int i = 0; i < 5; i++) begin
      for (int op = 3; op < 5; op++) begin
        a = tbl[i][15:8];
        m = tbl[i][7:0];
        r = a - m;
        f[0] = a >= m;
        f[1] = a[3:0] >= m[3:0];
        f[2] = r == 8'h00;
        f[3] = (a[7] != m[7]) && (r[7] != a[7]);
        f[4] = f[3] ^ r[7];
        f[5] = f[2];
        wr(skip_sub_pkg::OFS_ACC, {24'h0, a}, 1'b0);
        wr(ma(4'h6), {24'h0, m}, 1'b0);
        run(3'(op), 3'h0, 4'h6, 1'b0);
        if (op == 3) begin
          rd(skip_sub_pkg::OFS_ACC, {24'h0, r});
          rd(ma(4'h6), {24'h0, m});
        end else begin
          rd(ma(4'h6), {24'h0, r});
          rd(skip_sub_pkg::OFS_ACC, {24'h0, a});
        end
        rd(skip_sub_pkg::OFS_FLAGS, {26'h0, f});
      end
    end
  endtask

  task automatic t_swap();
    wr(skip_sub_pkg::OFS_FLAGS, 32'h15, 1'b0);
    wr(ma(4'hf), 32'h3c, 1'b0);
    run(3'h5, 3'h0, 4'hf, 1'b0);
    rd(ma(4'hf), 32'hc3);
    rd(skip_sub_pkg::OFS_FLAGS, 32'h15);
  endtask

  // Refused accesses: unmapped, read-only, unknown operation
  task automatic t_err();
    wr(12'h010, 32'h1, 1'b1);
    wr(skip_sub_pkg::OFS_STATUS, 32'h1, 1'b1);
    wr(skip_sub_pkg::OFS_CMD, 32'h6, 1'b1);
    rd(12'h010, 32'h0);
    rd(skip_sub_pkg::OFS_ACC, 32'h80);
  endtask

  // Main sequence
  initial begin
    @(posedge presetn);
    t_inc();
    t_nz();
    t_swap();
    t_err();
    t_sub();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
